// ==== common/cctl_pkg.sv ====
package cctl_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_ACK = 8'h01;
    localparam logic [7:0] OFS_INT_STATUS = 8'h02;
    localparam logic [7:0] OFS_INT_MASK = 8'h03;
    localparam logic [7:0] OFS_TIMER_LO = 8'h04;
    localparam logic [7:0] OFS_TIMER_HI = 8'h05;

    // ****************************************************************
    // Field positions of can_control_0
    // ****************************************************************
    localparam int BIT_RECEIVED_FRAME_FLAG = 7;
    localparam int BIT_RECEIVER_ACTIVE = 6;
    localparam int BIT_WAIT_STOP_CLOCKS = 5;
    localparam int BIT_BUS_SYNCHRONISED = 4;
    localparam int BIT_TIME = 3;
    localparam int BIT_WAKE_ON_TRAFFIC_ENABLE = 2;
    localparam int BIT_SLEEP_REQUEST = 1;
    localparam int BIT_INIT_REQUEST = 0;

    // Acknowledge register and interrupt status fields.
    localparam int BIT_SLEEP_ACK = 1;
    localparam int BIT_INIT_ACK = 0;
    localparam int BIT_INT_FRAME = 0;
    localparam int BIT_INT_WAKE = 1;
    localparam int BIT_INT_SLEEP = 2;

    // ****************************************************************
    // Reset values and counts
    // ****************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_INT = 3'h0;
    localparam logic [15:0] RST_TIMER = 16'h0000;
    localparam logic [3:0] SYNC_RECESSIVE_BITS = 4'hB;
    localparam logic [3:0] STAMP_ADDR_HI = 4'hE;
    localparam logic [3:0] STAMP_ADDR_LO = 4'hF;

    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_INIT} cctl_mode_t;

    // Status coming from the protocol engine, all on i_clk.
    typedef struct packed {
        logic frame_ok;
        logic rx_active;
        logic tx_empty;
        logic msg_ack;
        logic bit_tick;
        logic loopback;
    } cctl_core_t;

    // Timestamp byte write into the active message buffer.
    typedef struct packed {
        logic we;
        logic [3:0] addr;
        logic [7:0] data;
    } cctl_stamp_t;

endpackage

// ==== rtl/cctl_ctl0.sv ====
// What this block does
// RULE1: Valid received message sets the received-frame flag, whatever the filters say.
// RULE2: Writing one clears the received-frame flag; writing zero does nothing.
// RULE3: The received-frame flag stays set until software clear or reset.
// RULE4: In loopback the frame flag and receiver-active carry no meaning.
// RULE5: Receiver-active follows the receiver front end; zero when transmitting or idle.
// RULE6: Wait-stop set gates bus interface clocks in wait mode; clear means no effect.
// RULE7: Synchronised status is set and cleared only by the controller.
// RULE8: Timer enable starts a 16-bit counter stepping at bit rate.
// RULE9: Enabled timer stamps each acknowledged message into buffer bytes 0x0E and 0x0F.
// RULE10: A disabled timer is held at zero.
// RULE11: Timer enable is forced low during initialization mode.
// RULE12: Wake enable lets bus traffic end sleep; otherwise traffic is ignored.
// RULE13: Software sets wake enable before requesting sleep.
// RULE14: Initialization mode holds all bits but wake, sleep and init requests at reset.
// RULE15: Writes act only outside initialization mode, except the init request.
// RULE16: Sleep is entered only with bus idle, then acknowledged.
// RULE17: Init request aborts transfers, drops synchronisation, enters init, then acknowledged.
// RULE18: Hard reset clears frame flag, wait-stop, timer and wake enables, and counter.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
module cctl_ctl0 import cctl_pkg::*; (
    input wire logic i_clk, // Controller clock, 25 MHz.
    input wire logic i_rstn, // Synchronous reset, active low.
    input wire logic [7:0] i_addr, // Register address.
    input wire logic [7:0] i_wdata, // Register write data.
    input wire logic i_wr, // Write strobe.
    input wire logic i_rd, // Read strobe.
    output logic [7:0] o_rdata, // Read data, cycle after the strobe.
    input wire cctl_core_t i_core, // Protocol engine status.
    input wire logic i_wait_mode, // CPU is in wait mode.
    input wire logic i_bus_rx_pin, // Bus receive pin, asynchronous.
    output logic o_irq, // Interrupt, level high.
    output logic o_iface_clk_en, // Bus interface clock enable.
    output logic o_tx_recessive, // Force transmit pin recessive.
    output logic o_abort, // Abort transfers, one-cycle pulse.
    output logic o_sleep_ack, // Sleep acknowledge.
    output logic o_init_ack, // Initialization acknowledge.
    output logic o_wake, // Wake from sleep, one-cycle pulse.
    output logic [15:0] o_timer, // Timestamp counter value.
    output cctl_stamp_t o_stamp // Timestamp writes to the buffer.
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic received_frame_flag_reg, received_frame_flag_next;
    logic receiver_active_reg, receiver_active_next;
    logic wait_stop_clocks_reg, wait_stop_clocks_next;
    logic bus_synchronised_reg, bus_synchronised_next;
    logic time_reg, time_next;
    logic wake_on_traffic_enable_reg, wake_on_traffic_enable_next;
    logic sleep_request_reg, sleep_request_next;
    logic init_request_reg, init_request_next;
    logic init_acknowledge_reg, init_acknowledge_next;
    logic sleep_acknowledge_reg, sleep_acknowledge_next;
    logic wake_arm_reg, wake_arm_next;
    logic [3:0] rec_cnt_reg, rec_cnt_next;
    logic [2:0] int_stat_reg, int_stat_next;
    logic [2:0] int_mask_reg, int_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, clk_en_reg, tx_rec_reg, abort_reg, wake_reg;
    logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
    cctl_mode_t mode_reg, mode_next;
    logic [15:0] timer_count;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic init_mode = init_request_reg & init_acknowledge_reg;
    wire logic outside_init = ~init_request_reg & ~init_acknowledge_reg;
    wire logic wr_ctl0 = i_wr & hit(i_addr, OFS_CTL0);
    wire logic wr_ctl0_free = wr_ctl0 & outside_init; // RULE15
    wire logic wr_mask = i_wr & hit(i_addr, OFS_INT_MASK);
    wire logic rd_stat = i_rd & hit(i_addr, OFS_INT_STATUS);
    wire logic bus_idle = ~i_core.rx_active & i_core.tx_empty;
    wire logic rx_fall = rx_prev_reg & ~rx_sync_reg;
    wire logic frame_evt = i_core.frame_ok & ~i_core.loopback & ~init_mode; // RULE1 RULE4
    wire logic wake_evt = sleep_acknowledge_reg & wake_arm_reg & rx_fall; // RULE12
    wire logic sleep_evt = sleep_acknowledge_next & ~sleep_acknowledge_reg;
    wire logic [2:0] int_events = {sleep_evt, wake_evt, frame_evt};
    wire logic stop_clocks = i_wait_mode & wait_stop_clocks_reg;

    // ****************************************************************
    // Control register bits
    // ****************************************************************
    // Set wins over a same-cycle clear so no received frame is lost.
    assign received_frame_flag_next = init_mode ? 1'b0 :
                        frame_evt ? 1'b1 :
                        (wr_ctl0_free & i_wdata[BIT_RECEIVED_FRAME_FLAG]) ? 1'b0 : received_frame_flag_reg; // RULE2 RULE3 RULE14
    assign receiver_active_next = init_mode ? 1'b0 : i_core.rx_active; // RULE5 RULE14
    assign wait_stop_clocks_next = init_mode ? 1'b0 : (wr_ctl0_free ? i_wdata[BIT_WAIT_STOP_CLOCKS] : wait_stop_clocks_reg); // RULE14
    assign time_next = init_mode ? 1'b0 : (wr_ctl0_free ? i_wdata[BIT_TIME] : time_reg); // RULE11
    assign wake_on_traffic_enable_next = wr_ctl0_free ? i_wdata[BIT_WAKE_ON_TRAFFIC_ENABLE] : wake_on_traffic_enable_reg;
    // The sleep request cannot be withdrawn before the sleep is acknowledged.
    assign sleep_request_next = wake_evt ? 1'b0 :
                        wr_ctl0_free ? (i_wdata[BIT_SLEEP_REQUEST] | (sleep_request_reg & ~sleep_acknowledge_reg)) : sleep_request_reg;
    assign init_request_next = wr_ctl0 ? (i_wdata[BIT_INIT_REQUEST] | (init_request_reg & ~init_acknowledge_reg)) : init_request_reg; // RULE15
    assign init_acknowledge_next = init_request_reg; // RULE17
    assign sleep_acknowledge_next = sleep_request_reg & ~init_request_reg & (sleep_acknowledge_reg | bus_idle); // RULE16
    // Wake enable is sampled at sleep entry; later changes wait for the next sleep.
    assign wake_arm_next = sleep_evt ? wake_on_traffic_enable_reg : wake_arm_reg; // RULE13

    // ****************************************************************
    // Bus synchronisation
    // ****************************************************************
    // Eleven recessive bits in a row make the controller synchronised.
    assign rec_cnt_next = (init_request_reg | ~rx_sync_reg) ? 4'h0 :
                          (i_core.bit_tick & (rec_cnt_reg != SYNC_RECESSIVE_BITS)) ?
                          rec_cnt_reg + 4'h1 : rec_cnt_reg;
    assign bus_synchronised_next = (init_request_reg | sleep_acknowledge_reg) ? 1'b0 :
                        (rec_cnt_reg == SYNC_RECESSIVE_BITS) ? 1'b1 : bus_synchronised_reg; // RULE7 RULE17

    always_comb begin
        mode_next = MODE_RUN;
        case (mode_reg)
            MODE_RUN: begin
                if (init_mode) begin
                    mode_next = MODE_INIT;
                end else if (sleep_acknowledge_reg) begin
                    mode_next = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (init_mode) begin
                    mode_next = MODE_INIT;
                end else if (sleep_acknowledge_reg) begin
                    mode_next = MODE_SLEEP;
                end
            end
            MODE_INIT: begin
                if (!outside_init) begin
                    mode_next = MODE_INIT;
                end
            end
            default: begin
                mode_next = MODE_RUN;
            end
        endcase
    end

    // ****************************************************************
    // Interrupts and read data
    // ****************************************************************
    assign int_stat_next = (rd_stat ? RST_INT : int_stat_reg) | int_events;
    assign int_mask_next = wr_mask ? i_wdata[2:0] : int_mask_reg;

    wire logic [7:0] ctl0_view = {received_frame_flag_reg, receiver_active_reg, wait_stop_clocks_reg, bus_synchronised_reg,
                                  time_reg, wake_on_traffic_enable_reg, sleep_request_reg, init_request_reg};
    wire logic [7:0] ack_view = {6'h00, sleep_acknowledge_reg, init_acknowledge_reg};
    wire logic [7:0] read_mux = hit(i_addr, OFS_CTL0) ? ctl0_view :
                                hit(i_addr, OFS_ACK) ? ack_view :
                                hit(i_addr, OFS_INT_STATUS) ? {5'h00, int_stat_reg} :
                                hit(i_addr, OFS_INT_MASK) ? {5'h00, int_mask_reg} :
                                hit(i_addr, OFS_TIMER_LO) ? timer_count[7:0] :
                                hit(i_addr, OFS_TIMER_HI) ? timer_count[15:8] : RST_BYTE;
    assign rdata_next = i_rd ? read_mux : RST_BYTE;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            received_frame_flag_reg <= 1'b0;
            receiver_active_reg <= 1'b0;
            wait_stop_clocks_reg <= 1'b0;
            bus_synchronised_reg <= 1'b0;
            time_reg <= 1'b0;
            wake_on_traffic_enable_reg <= 1'b0;
            sleep_request_reg <= 1'b0;
            init_request_reg <= 1'b0;
            init_acknowledge_reg <= 1'b0;
            sleep_acknowledge_reg <= 1'b0;
            wake_arm_reg <= 1'b0;
            rec_cnt_reg <= 4'h0;
            mode_reg <= MODE_RUN;
        end else begin // RULE18
            received_frame_flag_reg <= received_frame_flag_next;
            receiver_active_reg <= receiver_active_next;
            wait_stop_clocks_reg <= wait_stop_clocks_next;
            bus_synchronised_reg <= bus_synchronised_next;
            time_reg <= time_next;
            wake_on_traffic_enable_reg <= wake_on_traffic_enable_next;
            sleep_request_reg <= sleep_request_next;
            init_request_reg <= init_request_next;
            init_acknowledge_reg <= init_acknowledge_next;
            sleep_acknowledge_reg <= sleep_acknowledge_next;
            wake_arm_reg <= wake_arm_next;
            rec_cnt_reg <= rec_cnt_next;
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            int_stat_reg <= RST_INT;
            int_mask_reg <= RST_INT;
            rdata_reg <= RST_BYTE;
            irq_reg <= 1'b0;
            clk_en_reg <= 1'b1;
            tx_rec_reg <= 1'b1;
            abort_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= |(int_stat_next & int_mask_next);
            clk_en_reg <= ~stop_clocks; // RULE6
            tx_rec_reg <= stop_clocks | init_request_next;
            abort_reg <= init_request_next & ~init_request_reg; // RULE17
            wake_reg <= wake_evt;
        end
    end

    // Bus pin synchroniser; reset leaves it recessive.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= i_bus_rx_pin;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    cctl_stamp_timer u_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_enable(time_reg),
        .i_bit_tick(i_core.bit_tick),
        .i_capture(i_core.msg_ack),
        .o_count(timer_count),
        .o_stamp(o_stamp)
    );

    assign o_rdata = rdata_reg;
    assign o_irq = irq_reg;
    assign o_iface_clk_en = clk_en_reg;
    assign o_tx_recessive = tx_rec_reg;
    assign o_abort = abort_reg;
    assign o_sleep_ack = sleep_acknowledge_reg;
    assign o_init_ack = init_acknowledge_reg;
    assign o_wake = wake_reg;
    assign o_timer = timer_count;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_frame_sets_flag: // RULE1
    assert property (@(posedge i_clk) disable iff (!i_rstn) frame_evt |=> received_frame_flag_reg)
        else $error("Received frame did not set the flag.");

    a_zero_write_keeps: // RULE2
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        (received_frame_flag_reg & wr_ctl0 & ~i_wdata[BIT_RECEIVED_FRAME_FLAG] & ~init_mode) |=> received_frame_flag_reg)
        else $error("Writing zero cleared the frame flag.");

    a_flag_sticky: // RULE3
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        (received_frame_flag_reg & ~wr_ctl0 & ~init_mode) |=> received_frame_flag_reg)
        else $error("Frame flag dropped without a clear.");

    a_receiver_active_follows: // RULE5
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        ~init_mode |=> (receiver_active_reg == $past(i_core.rx_active)))
        else $error("Receiver active does not follow the front end.");

    a_clock_gate: // RULE6
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_wait_mode & wait_stop_clocks_reg) |=> ~o_iface_clk_en)
        else $error("Interface clock not stopped in wait mode.");

    a_timer_zero: // RULE10
    assert property (@(posedge i_clk) disable iff (!i_rstn) ~time_reg |=> (timer_count == 16'h0000))
        else $error("Disabled timer is not zero.");

    a_timer_counts: // RULE8
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        (time_reg & $past(time_reg) & $past(i_core.bit_tick)) |-> (timer_count == $past(timer_count) + 16'h0001))
        else $error("Timer did not step on a bit tick.");

    a_init_holds: // RULE11
    assert property (@(posedge i_clk) disable iff (!i_rstn) init_mode |=> (~time_reg & ~wait_stop_clocks_reg & ~received_frame_flag_reg))
        else $error("Initialization mode did not hold the bits.");

    a_init_handshake: // RULE17
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(init_request_reg) |-> ##1 (o_init_ack & ~bus_synchronised_reg) [*2])
        else $error("Init request not acknowledged in one cycle.");

    a_sleep_idle: // RULE16
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(sleep_acknowledge_reg) |-> $past(bus_idle & sleep_request_reg))
        else $error("Sleep entered with the bus busy.");

    a_wake_gated: // RULE12
    assert property (@(posedge i_clk) disable iff (!i_rstn) (sleep_acknowledge_reg & ~wake_arm_reg) |=> ~o_wake)
        else $error("Wake raised with wake-up disabled.");

    a_stamp_pair: // RULE9
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        (time_reg & i_core.msg_ack) |=> (o_stamp.we && o_stamp.addr == STAMP_ADDR_HI) ##1
        (o_stamp.we && o_stamp.addr == STAMP_ADDR_LO))
        else $error("Timestamp bytes not written in order.");

endmodule

// ==== rtl/cctl_stamp_timer.sv ====
`timescale 1ns/10ps
module cctl_stamp_timer import cctl_pkg::*; (
    input wire logic i_clk, // Controller clock.
    input wire logic i_rstn, // Synchronous reset, active low.
    input wire logic i_enable, // Timer enable.
    input wire logic i_bit_tick, // One pulse per bit time.
    input wire logic i_capture, // Message acknowledged on the bus.
    output logic [15:0] o_count, // Free-running count.
    output cctl_stamp_t o_stamp // Timestamp byte writes.
);

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic pend_reg;
    logic pend_next;
    cctl_stamp_t stamp_reg;
    cctl_stamp_t stamp_next;
    wire logic capture_go = i_enable & i_capture;

    // ****************************************************************
    // Counter and two-byte write
    // ****************************************************************
    assign count_next = !i_enable ? RST_TIMER : (i_bit_tick ? count_reg + 16'h0001 : count_reg); // RULE8 RULE10
    // High byte goes out the cycle after the capture, the low byte the cycle after that.
    assign stamp_next = capture_go ? '{we: 1'b1, addr: STAMP_ADDR_HI, data: count_reg[15:8]} :
                        pend_reg ? '{we: 1'b1, addr: STAMP_ADDR_LO, data: low_reg} :
                        '{we: 1'b0, addr: 4'h0, data: 8'h00}; // RULE9
    assign pend_next = capture_go;
    assign low_next = capture_go ? count_reg[7:0] : low_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            count_reg <= RST_TIMER;
            low_reg <= RST_BYTE;
            pend_reg <= 1'b0;
            stamp_reg <= '0;
        end else begin
            count_reg <= count_next;
            low_reg <= low_next;
            pend_reg <= pend_next;
            stamp_reg <= stamp_next;
        end
    end

    assign o_count = count_reg;
    assign o_stamp = stamp_reg;

endmodule

// ==== tb/cctl_core_model.sv ====
`timescale 1ns/10ps
module cctl_core_model import cctl_pkg::*; (
    input wire logic i_clk, // Controller clock.
    input wire logic i_rstn, // Synchronous reset, active low.
    input wire logic i_send, // Start one received frame, one-cycle pulse.
    input wire logic i_bus_level, // Bus level outside frames, 1 is recessive.
    output cctl_core_t o_core, // Engine status towards the block.
    output logic o_rx_pin // Bus receive pin.
);
    logic [1:0] tick_reg;
    logic [3:0] frame_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tick_reg <= 2'h0;
            frame_reg <= 4'h0;
        end else begin
            tick_reg <= tick_reg + 2'h1;
            if (i_send) begin
                frame_reg <= 4'hC;
            end else if (frame_reg != 4'h0) begin
                frame_reg <= frame_reg - 4'h1;
            end
        end
    end

    assign o_core.bit_tick = (tick_reg == 2'h3);
    assign o_core.rx_active = (frame_reg != 4'h0);
    assign o_core.frame_ok = (frame_reg == 4'h1);
    assign o_core.msg_ack = (frame_reg == 4'h1);
    assign o_core.tx_empty = 1'b1;
    assign o_core.loopback = 1'b0;
    // The wire toggles every cycle inside a frame, so it never looks like an idle bus.
    assign o_rx_pin = (frame_reg != 4'h0) ? frame_reg[0] : i_bus_level;
endmodule

// ==== tb/cctl_ctl0_tb.sv ====
`timescale 1ns/10ps
module cctl_ctl0_tb import cctl_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rstn, i_wr, i_rd, i_wait_mode, send, bus_level, rx_pin, seen;
    logic [7:0] i_addr, i_wdata, o_rdata, d, t0, t1;
    logic o_irq, o_iface_clk_en, o_tx_recessive, o_abort, o_sleep_ack, o_init_ack, o_wake;
    logic [15:0] o_timer;
    cctl_core_t core;
    cctl_stamp_t o_stamp;
    logic [3:0] st_addr[$];
    logic [7:0] st_data[$];
    int miscompares = 0;
    int tests_run = 0;

    always #20 i_clk = ~i_clk;

    cctl_core_model u_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_send(send), .i_bus_level(bus_level),
        .o_core(core), .o_rx_pin(rx_pin));
    cctl_ctl0 DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_core(core), .i_wait_mode(i_wait_mode), .i_bus_rx_pin(rx_pin),
        .o_irq(o_irq), .o_iface_clk_en(o_iface_clk_en), .o_tx_recessive(o_tx_recessive), .o_abort(o_abort),
        .o_sleep_ack(o_sleep_ack), .o_init_ack(o_init_ack), .o_wake(o_wake), .o_timer(o_timer),
        .o_stamp(o_stamp));

    // Sampled on the falling edge so the registered byte writes are settled.
    always @(negedge i_clk) begin
        if (o_stamp.we === 1'b1) begin
            st_addr.push_back(o_stamp.addr);
            st_data.push_back(o_stamp.data);
        end
    end

    // ****************************************************************
    // Bus access and comparison tasks
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic watch_wake;
        seen = 1'b0;
        repeat (10) begin
            @(posedge i_clk);
            #1;
            if (o_wake === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        final_report;
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        i_rstn = 1'b0; i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
        i_wait_mode = 1'b0; send = 1'b0; bus_level = 1'b1;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(OFS_CTL0, d); chk8(d, 8'h00);
        chk1(o_iface_clk_en, 1'b1);
        chk1(o_tx_recessive, 1'b0);
        repeat (60) @(posedge i_clk);
        rd(OFS_CTL0, d); chk8(d, 8'h10);
        wr(OFS_CTL0, 8'h6C);
        rd(OFS_CTL0, d); chk8(d, 8'h3C);
        @(posedge i_clk); i_wait_mode <= 1'b1;
        repeat (2) @(posedge i_clk); #1;
        chk1(o_iface_clk_en, 1'b0);
        i_wait_mode <= 1'b0;
        rd(OFS_TIMER_LO, t0); repeat (38) @(posedge i_clk); rd(OFS_TIMER_LO, t1);
        chk8(t1 - t0, 8'h0A);
        wr(OFS_INT_MASK, 8'h07);
        rd(OFS_INT_MASK, d); chk8(d, 8'h07);
        @(posedge i_clk); send <= 1'b1;
        @(posedge i_clk); send <= 1'b0;
        repeat (4) @(posedge i_clk);
        rd(OFS_CTL0, d); chk8(d & 8'h40, 8'h40);
        repeat (12) @(posedge i_clk); #1;
        chk1(o_irq, 1'b1);
        rd(OFS_CTL0, d); chk8(d & 8'hEF, 8'hAC);
        chk8(8'(st_addr.size()), 8'h02);
        chk8({4'h0, st_addr[0]}, {4'h0, STAMP_ADDR_HI});
        chk8({4'h0, st_addr[1]}, {4'h0, STAMP_ADDR_LO});
        chk8(st_data[0], 8'h00);
        rd(OFS_INT_STATUS, d); chk8(d, 8'h01);
        chk1(o_irq, 1'b0);
        rd(OFS_INT_STATUS, d); chk8(d, 8'h00);
        wr(OFS_CTL0, 8'h2C);
        rd(OFS_CTL0, d); chk8(d & 8'hEF, 8'hAC);
        wr(OFS_CTL0, 8'hAC);
        rd(OFS_CTL0, d); chk8(d & 8'hEF, 8'h2C);
        wr(8'h10, 8'hFF);
        rd(8'h10, d); chk8(d, 8'h00);
        wr(OFS_CTL0, 8'h2D); #1;
        chk1(o_abort, 1'b1);
        chk1(o_tx_recessive, 1'b1);
        repeat (3) @(posedge i_clk);
        rd(OFS_CTL0, d); chk8(d, 8'h05);
        rd(OFS_ACK, d); chk8(d, 8'h01);
        rd(OFS_TIMER_LO, d); chk8(d, 8'h00);
        chk8(o_timer[15:8], 8'h00);
        chk8(o_timer[7:0], 8'h00);
        wr(OFS_CTL0, 8'h29);
        rd(OFS_CTL0, d); chk8(d, 8'h05);
        wr(OFS_CTL0, 8'h00);
        repeat (3) @(posedge i_clk);
        rd(OFS_ACK, d); chk8(d, 8'h00);
        rd(OFS_CTL0, d); chk8(d & 8'hEF, 8'h04);
        @(posedge i_clk); i_wait_mode <= 1'b1;
        repeat (2) @(posedge i_clk); #1;
        chk1(o_iface_clk_en, 1'b1);
        i_wait_mode <= 1'b0;
        // Wake enable is already set before the request, as software must do.
        wr(OFS_CTL0, 8'h06);
        repeat (3) @(posedge i_clk); #1;
        chk1(o_sleep_ack, 1'b1);
        bus_level <= 1'b0;
        watch_wake; chk1(seen, 1'b1);
        bus_level <= 1'b1;
        repeat (3) @(posedge i_clk); #1;
        chk1(o_sleep_ack, 1'b0);
        rd(OFS_INT_STATUS, d); chk8(d, 8'h06);
        wr(OFS_CTL0, 8'h00);
        wr(OFS_CTL0, 8'h02);
        repeat (3) @(posedge i_clk);
        bus_level <= 1'b0;
        watch_wake; chk1(seen, 1'b0);
        chk1(o_sleep_ack, 1'b1);
        bus_level <= 1'b1;
        wr(OFS_CTL0, 8'h00);
        repeat (3) @(posedge i_clk); #1;
        chk1(o_sleep_ack, 1'b0);
        final_report;
    end
endmodule
